// ==== rtl/tcc_channel1.sv ====
// tcc_channel1.sv: channel 1 counter with two capture/compare registers
// assumes: register master on clk, count ticks and channel 0 events are clk pulses,
// pins are asynchronous and resolved by the surrounding pad logic
//
// Contract
// RULE_01: register A in a compare code with high start level drives low, high or toggles on match.
// RULE_02: register A codes 1000, 1001 and 101x capture the counter on rising, falling or both pin edges.
// RULE_03: register A codes 11xx capture the counter on a channel 0 register A match or capture.
// RULE_04: register B codes 0000 and 0100 keep pin B undriven, 0001-0011 start low, 0101-0111 high.
// RULE_05: register B compare codes act on match by low bits: 01 low, 10 high, 11 toggle.
// RULE_06: register B codes 1000, 1001 and 101x capture the counter on rising, falling or both pin edges.
// RULE_07: register B codes 11xx capture the counter on a channel 0 register match or capture.
// RULE_08: conversion start requests leave only while the enable bit in the enable register is one.
// RULE_09: status flags are cleared by writing zero and a written one never sets them.
// RULE_10: the counter counts down only in phase counting or cascade mode, otherwise only up.
// RULE_11: a two-bit select clears the counter never, on register A, on register B, or on sync clear.
// RULE_12: a compare match is seen in the cycle the counter equals the general register.
`timescale 1ns/1ps
`default_nettype none
`include "tcc_regs.svh"

module tcc_channel1
  import tcc_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [15:0] addr,
  input wire logic [15:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [15:0] rd_data,
  input wire logic tick_up,
  input wire logic tick_down,
  input wire logic ch0_a_event,
  input wire logic ch0_b_event,
  input wire logic sync_clear,
  input wire logic pin_a_in,
  output logic pin_a_out,
  output logic pin_a_oe_n,
  input wire logic pin_b_in,
  output logic pin_b_out,
  output logic pin_b_oe_n,
  output logic adc_start,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////////
  // declarations
  logic [7:0] ctrl_reg;
  logic [7:0] mode_reg;
  logic [7:0] io_reg;
  logic [7:0] ie_reg;
  logic [7:0] stat_reg;
  logic [7:0] stat_next;
  logic [15:0] cnt_reg;
  logic [15:0] gra_reg;
  logic [15:0] grb_reg;
  logic [15:0] rd_data_reg;
  logic io_load_reg;
  logic eq_a_prev_reg;
  logic eq_b_prev_reg;
  logic adc_start_reg;
  logic irq_reg;
  tcc_io_code_t code_a;
  tcc_io_code_t code_b;
  logic wr_ctrl;
  logic wr_mode;
  logic wr_io;
  logic wr_ie;
  logic wr_stat;
  logic wr_cnt;
  logic wr_gra;
  logic wr_grb;
  logic eq_a;
  logic eq_b;
  logic match_a;
  logic match_b;
  logic cap_a;
  logic cap_b;
  logic event_a;
  logic event_b;
  logic updown;
  logic cnt_clear;
  logic cnt_inc;
  logic cnt_dec;
  logic ovf;
  logic unf;
  logic [1:0] clr_sel;

  // address match for a write; strobe and address come in as arguments so the decode follows them
  function automatic logic wr_hit(input logic en, input logic [15:0] at, input logic [15:0] a);
    return en && (at == a);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // write decode
  assign wr_ctrl = wr_hit(wr_en, addr, `TCC_ADDR_CTRL);
  assign wr_mode = wr_hit(wr_en, addr, `TCC_ADDR_MODE);
  assign wr_io = wr_hit(wr_en, addr, `TCC_ADDR_IO);
  assign wr_ie = wr_hit(wr_en, addr, `TCC_ADDR_IE);
  assign wr_stat = wr_hit(wr_en, addr, `TCC_ADDR_STAT);
  assign wr_cnt = wr_hit(wr_en, addr, `TCC_ADDR_CNT);
  assign wr_gra = wr_hit(wr_en, addr, `TCC_ADDR_GRA);
  assign wr_grb = wr_hit(wr_en, addr, `TCC_ADDR_GRB);

  assign code_a = io_reg[`TCC_IO_A_HI:`TCC_IO_A_LO];
  assign code_b = io_reg[`TCC_IO_B_HI:`TCC_IO_B_LO];
  assign clr_sel = ctrl_reg[`TCC_CTRL_CLR_HI:`TCC_CTRL_CLR_LO];

  ////////////////////////////////////////////////////////////////////////////////
  // plain configuration registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrl_reg <= `TCC_RST_BYTE;
      mode_reg <= `TCC_RST_BYTE;
      io_reg <= `TCC_RST_BYTE;
      ie_reg <= `TCC_RST_BYTE;
    end else begin
      if (wr_ctrl) begin
        ctrl_reg <= wr_data[7:0];
      end
      if (wr_mode) begin
        mode_reg <= wr_data[7:0];
      end
      if (wr_io) begin
        io_reg <= wr_data[7:0];
      end
      if (wr_ie) begin
        ie_reg <= wr_data[7:0];
      end
    end
  end

  // pulse after an i/o write so the pins see the stored code
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      io_load_reg <= 1'b0;
    end else begin
      io_load_reg <= wr_io;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // compare match: first cycle of equality in a compare code
  assign eq_a = (cnt_reg == gra_reg);
  assign eq_b = (cnt_reg == grb_reg);
  assign match_a = eq_a && !eq_a_prev_reg && (tcc_io_mode(code_a) == TCC_IO_CMP); // RULE_12
  assign match_b = eq_b && !eq_b_prev_reg && (tcc_io_mode(code_b) == TCC_IO_CMP); // RULE_12

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      eq_a_prev_reg <= 1'b0;
      eq_b_prev_reg <= 1'b0;
    end else begin
      eq_a_prev_reg <= eq_a;
      eq_b_prev_reg <= eq_b;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // capture triggers for both general registers
  tcc_edge_capture u_cap_a (
    .clk(clk),
    .sys_rst(sys_rst),
    .pin_raw(pin_a_in),
    .code(code_a),
    .ch0_event(ch0_a_event),
    .pin_level(),
    .capture(cap_a)
  );

  tcc_edge_capture u_cap_b (
    .clk(clk),
    .sys_rst(sys_rst),
    .pin_raw(pin_b_in),
    .code(code_b),
    .ch0_event(ch0_b_event),
    .pin_level(),
    .capture(cap_b)
  );

  assign event_a = match_a | cap_a;
  assign event_b = match_b | cap_b;

  // general registers: a capture wins over a software write
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      gra_reg <= `TCC_RST_GR;
      grb_reg <= `TCC_RST_GR;
    end else begin
      if (cap_a) begin
        gra_reg <= cnt_reg; // RULE_02 RULE_03
      end else if (wr_gra) begin
        gra_reg <= wr_data;
      end
      if (cap_b) begin
        grb_reg <= cnt_reg; // RULE_06 RULE_07
      end else if (wr_grb) begin
        grb_reg <= wr_data;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // counter: write, then clear, then count
  assign updown = (mode_reg[`TCC_MODE_HI:`TCC_MODE_LO] == `TCC_MODE_PHASE) ||
                  (ctrl_reg[`TCC_CTRL_SRC_HI:`TCC_CTRL_SRC_LO] == `TCC_SRC_CASCADE); // RULE_10

  always_comb begin
    unique case (clr_sel)
      `TCC_CLR_NONE: cnt_clear = 1'b0; // RULE_11
      `TCC_CLR_A: cnt_clear = event_a; // RULE_11
      `TCC_CLR_B: cnt_clear = event_b; // RULE_11
      `TCC_CLR_SYNC: cnt_clear = sync_clear; // RULE_11
    endcase
  end

  assign cnt_inc = !wr_cnt && !cnt_clear && tick_up;
  assign cnt_dec = !wr_cnt && !cnt_clear && !tick_up && tick_down && updown; // RULE_10
  assign ovf = cnt_inc && (cnt_reg == `TCC_CNT_MAX);
  assign unf = cnt_dec && (cnt_reg == `TCC_RST_CNT);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cnt_reg <= `TCC_RST_CNT;
    end else if (wr_cnt) begin
      cnt_reg <= wr_data;
    end else if (cnt_clear) begin
      cnt_reg <= `TCC_RST_CNT; // RULE_11
    end else if (cnt_inc) begin
      cnt_reg <= cnt_reg + 16'h0001;
    end else if (cnt_dec) begin
      cnt_reg <= cnt_reg - 16'h0001; // RULE_10
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // status flags: written zero clears, written one keeps, a new event wins
  always_comb begin
    stat_next = stat_reg;
    if (wr_stat) begin
      stat_next = stat_reg & (wr_data[7:0] | ~`TCC_FLG_MASK); // RULE_09
    end
    stat_next[`TCC_FLG_A] = stat_next[`TCC_FLG_A] | event_a;
    stat_next[`TCC_FLG_B] = stat_next[`TCC_FLG_B] | event_b;
    stat_next[`TCC_FLG_OVF] = stat_next[`TCC_FLG_OVF] | ovf;
    stat_next[`TCC_FLG_UNF] = stat_next[`TCC_FLG_UNF] | unf;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      stat_reg <= `TCC_RST_BYTE;
    end else begin
      stat_reg <= stat_next & `TCC_FLG_MASK;
    end
  end

  // level interrupt from enabled flags
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(stat_reg & ie_reg & `TCC_FLG_MASK);
    end
  end

  // conversion start pulse on register A event, gated by its enable
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      adc_start_reg <= 1'b0;
    end else begin
      adc_start_reg <= event_a && ie_reg[`TCC_IE_ADC]; // RULE_08
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // compare outputs on the two pins
  tcc_pin_out u_out_a (
    .clk(clk),
    .sys_rst(sys_rst),
    .code(code_a),
    .load(io_load_reg),
    .match(match_a),
    .pin_out_reg(pin_a_out),
    .pin_oe_n_reg(pin_a_oe_n)
  );

  tcc_pin_out u_out_b (
    .clk(clk),
    .sys_rst(sys_rst),
    .code(code_b),
    .load(io_load_reg),
    .match(match_b),
    .pin_out_reg(pin_b_out),
    .pin_oe_n_reg(pin_b_oe_n)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // read port: data one cycle after the strobe, zero elsewhere
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rd_data_reg <= 16'h0000;
    end else if (rd_en) begin
      unique case (addr)
        `TCC_ADDR_CTRL: rd_data_reg <= {8'h00, ctrl_reg};
        `TCC_ADDR_MODE: rd_data_reg <= {8'h00, mode_reg};
        `TCC_ADDR_IO: rd_data_reg <= {8'h00, io_reg};
        `TCC_ADDR_IE: rd_data_reg <= {8'h00, ie_reg};
        `TCC_ADDR_STAT: rd_data_reg <= {8'h00, stat_reg};
        `TCC_ADDR_CNT: rd_data_reg <= cnt_reg;
        `TCC_ADDR_GRA: rd_data_reg <= gra_reg;
        `TCC_ADDR_GRB: rd_data_reg <= grb_reg;
        default: rd_data_reg <= 16'h0000;
      endcase
    end else begin
      rd_data_reg <= 16'h0000;
    end
  end

  assign rd_data = rd_data_reg;
  assign adc_start = adc_start_reg;
  assign irq = irq_reg;

endmodule // tcc_channel1

`default_nettype wire

// ==== rtl/tcc_regs.svh ====
// tcc_regs.svh: register offsets, field positions, reset values of the channel 1 timer
// assumes: byte addresses on a 16-bit register port, 8-bit registers in the low bits
`ifndef TCC_REGS_SVH
`define TCC_REGS_SVH

////////////////////////////////////////////////////////////////////////////////
// register byte addresses
`define TCC_ADDR_CTRL 16'hffe0
`define TCC_ADDR_MODE 16'hffe1
`define TCC_ADDR_IO 16'hffe2
`define TCC_ADDR_IE 16'hffe4
`define TCC_ADDR_STAT 16'hffe5
`define TCC_ADDR_CNT 16'hffe6
`define TCC_ADDR_GRA 16'hffe8
`define TCC_ADDR_GRB 16'hffea

////////////////////////////////////////////////////////////////////////////////
// field positions
`define TCC_CTRL_CLR_HI 6
`define TCC_CTRL_CLR_LO 5
`define TCC_CTRL_SRC_HI 2
`define TCC_CTRL_SRC_LO 0
`define TCC_SRC_CASCADE 3'h7
`define TCC_MODE_HI 3
`define TCC_MODE_LO 2
`define TCC_MODE_PHASE 2'h1
`define TCC_IO_A_HI 3
`define TCC_IO_A_LO 0
`define TCC_IO_B_HI 7
`define TCC_IO_B_LO 4
`define TCC_FLG_A 0
`define TCC_FLG_B 1
`define TCC_FLG_OVF 4
`define TCC_FLG_UNF 5
`define TCC_IE_ADC 7
`define TCC_FLG_MASK 8'h33
`define TCC_CLR_NONE 2'h0
`define TCC_CLR_A 2'h1
`define TCC_CLR_B 2'h2
`define TCC_CLR_SYNC 2'h3

////////////////////////////////////////////////////////////////////////////////
// reset values
`define TCC_RST_BYTE 8'h00
`define TCC_RST_CNT 16'h0000
`define TCC_RST_GR 16'hffff
`define TCC_CNT_MAX 16'hffff

`endif

// ==== rtl/tcc_pkg.sv ====
// tcc_pkg.sv: types and decode helpers shared by the channel 1 timer files
// assumes: nothing beyond the tool's package support
package tcc_pkg;

  typedef logic [3:0] tcc_io_code_t;

  typedef enum logic [1:0] {
    TCC_IO_OFF,
    TCC_IO_CMP,
    TCC_IO_CAP_PIN,
    TCC_IO_CAP_CH0
  } tcc_io_mode_t;

  // classify a 4-bit i/o control code
  function automatic tcc_io_mode_t tcc_io_mode(input tcc_io_code_t code);
    if (code[3] && code[2]) begin
      return TCC_IO_CAP_CH0;
    end else if (code[3]) begin
      return TCC_IO_CAP_PIN;
    end else if (code[1:0] == 2'h0) begin
      return TCC_IO_OFF;
    end else begin
      return TCC_IO_CMP;
    end
  endfunction

endpackage

// ==== rtl/tcc_pin_out.sv ====
// tcc_pin_out.sv: compare-match output level and enable for one timer pin
// assumes: load pulses one cycle after the i/o code was written, match is one cycle wide
`timescale 1ns/1ps
`default_nettype none

module tcc_pin_out
  import tcc_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire tcc_io_code_t code,
  input wire logic load,
  input wire logic match,
  output logic pin_out_reg,
  output logic pin_oe_n_reg
);

  ////////////////////////////////////////////////////////////////////////////////
  // pin level: initial level on load, then per match action
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pin_out_reg <= 1'b0;
    end else if (load && code[3] == 1'b0) begin
      pin_out_reg <= code[2]; // RULE_04
    end else if (match && tcc_io_mode(code) == TCC_IO_CMP) begin
      unique case (code[1:0])
        2'h1: pin_out_reg <= 1'b0; // RULE_01 RULE_05
        2'h2: pin_out_reg <= 1'b1; // RULE_01 RULE_05
        2'h3: pin_out_reg <= ~pin_out_reg; // RULE_01 RULE_05
        default: pin_out_reg <= pin_out_reg;
      endcase
    end
  end

  // drive enable low only in an active compare code
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pin_oe_n_reg <= 1'b1;
    end else begin
      pin_oe_n_reg <= (tcc_io_mode(code) != TCC_IO_CMP); // RULE_04
    end
  end

endmodule // tcc_pin_out

`default_nettype wire

// ==== rtl/tcc_edge_capture.sv ====
// tcc_edge_capture.sv: input capture trigger for one general register
// assumes: pin_raw is asynchronous, ch0_event is a one-cycle pulse on clk
`timescale 1ns/1ps
`default_nettype none

module tcc_edge_capture
  import tcc_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic pin_raw,
  input wire tcc_io_code_t code,
  input wire logic ch0_event,
  output logic pin_level,
  output logic capture
);

  logic sync1_reg;
  logic sync2_reg;
  logic prev_reg;
  logic rise;
  logic fall;

  ////////////////////////////////////////////////////////////////////////////////
  // two-stage synchroniser plus one history stage
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      prev_reg <= 1'b0;
    end else begin
      sync1_reg <= pin_raw;
      sync2_reg <= sync1_reg;
      prev_reg <= sync2_reg;
    end
  end

  assign pin_level = sync2_reg;
  assign rise = sync2_reg & ~prev_reg;
  assign fall = ~sync2_reg & prev_reg;

  // pick the trigger that the code selects
  always_comb begin
    capture = 1'b0;
    unique case (tcc_io_mode(code))
      TCC_IO_CAP_PIN: begin
        if (code[1]) begin
          capture = rise | fall; // RULE_02 RULE_06
        end else if (code[0]) begin
          capture = fall; // RULE_02 RULE_06
        end else begin
          capture = rise; // RULE_02 RULE_06
        end
      end
      TCC_IO_CAP_CH0: capture = ch0_event; // RULE_03 RULE_07
      TCC_IO_OFF, TCC_IO_CMP: capture = 1'b0;
    endcase
  end

endmodule // tcc_edge_capture

`default_nettype wire

// ==== sim/tcc_channel1_assertions.sv ====
// tcc_channel1_assertions.sv: port-level checks of the channel 1 timer
// assumes: bound to tcc_channel1, a single clock domain on clk
`timescale 1ns/1ps
`default_nettype none

module tcc_channel1_checker (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [15:0] addr,
  input wire logic [15:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [15:0] rd_data,
  input wire logic tick_up,
  input wire logic tick_down,
  input wire logic ch0_a_event,
  input wire logic ch0_b_event,
  input wire logic sync_clear,
  input wire logic pin_a_in,
  input wire logic pin_a_out,
  input wire logic pin_a_oe_n,
  input wire logic pin_b_in,
  input wire logic pin_b_out,
  input wire logic pin_b_oe_n,
  input wire logic adc_start,
  input wire logic irq
);
  logic [7:0] ie_reg;
  logic [7:0] io_reg;
  logic [2:0] io_age_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // shadow copies of the enable and i/o control writes, age of the last i/o write
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ie_reg <= 8'h00;
      io_reg <= 8'h00;
      io_age_reg <= 3'h7;
    end else begin
      if (wr_en && addr == 16'hffe4) ie_reg <= wr_data[7:0];
      if (wr_en && addr == 16'hffe2) io_reg <= wr_data[7:0];
      if (wr_en && addr == 16'hffe2) io_age_reg <= 3'h0;
      else if (io_age_reg != 3'h7) io_age_reg <= io_age_reg + 3'h1;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  ////////////////////////////////////////////////////////////////////////////////
  // read port, interrupt and converter requests
  rd_idle_zero_a: assert property (!$past(rd_en) |-> rd_data == 16'h0000)
    else $error("read data not zero outside a read");
  unmapped_read_a: assert property ($past(rd_en) && $past(addr) == 16'hffe3 |-> rd_data == 16'h0000)
    else $error("unmapped read not zero");
  flag_bits_a: assert property ($past(rd_en) && $past(addr) == 16'hffe5
    |-> (rd_data & 16'hffcc) == 16'h0000) else $error("unused flag bits set");
  adc_enable_a: assert property (adc_start |-> $past(ie_reg[7]))
    else $error("conversion start while disabled");
  adc_pulse_a: assert property (adc_start |=> !adc_start)
    else $error("conversion start longer than one cycle");
  irq_enable_a: assert property (irq |-> (($past(ie_reg) | $past(ie_reg, 2)) & 8'h33) != 8'h00)
    else $error("interrupt without enable");
  // pin drivers after an i/o code has settled
  pin_a_on_a: assert property (io_age_reg > 3'h3 && !io_reg[3] && io_reg[1:0] != 2'h0
    |-> !pin_a_oe_n) else $error("pin a not driven in compare code");
  pin_b_off_a: assert property (io_age_reg > 3'h3 && !io_reg[7] && io_reg[5:4] == 2'h0
    |-> pin_b_oe_n) else $error("pin b driven while disabled");
  pin_b_on_a: assert property (io_age_reg > 3'h3 && !io_reg[7] && io_reg[5:4] != 2'h0
    |-> !pin_b_oe_n) else $error("pin b not driven in compare code");
  pin_b_start_a: assert property (io_age_reg == 3'h4 && !io_reg[7] && io_reg[5:4] != 2'h0
    |-> pin_b_out == io_reg[6]) else $error("pin b start level wrong");
endmodule // tcc_channel1_checker

`default_nettype wire

// ==== sim/tcc_far_side.sv ====
// tcc_far_side.sv: pads and converter beyond the channel 1 timer pins
// assumes: ext_a and ext_b are outside sources, seen only while the timer releases a pin
`timescale 1ns/1ps
`default_nettype none

module tcc_far_side (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic pin_a_out,
  input wire logic pin_a_oe_n,
  input wire logic pin_b_out,
  input wire logic pin_b_oe_n,
  input wire logic ext_a,
  input wire logic ext_b,
  input wire logic adc_start,
  output logic pin_a_in,
  output logic pin_b_in,
  output int adc_count
);
  // wire level: the timer wins while it drives, else the outside source
  assign pin_a_in = pin_a_oe_n ? ext_a : pin_a_out;
  assign pin_b_in = pin_b_oe_n ? ext_b : pin_b_out;

  // converter counts every start request it receives
  always @(posedge clk) begin
    if (sys_rst) adc_count <= 0;
    else if (adc_start) adc_count <= adc_count + 1;
  end
endmodule // tcc_far_side

`default_nettype wire

// ==== sim/tb_tcc_channel1.sv ====
// tb_tcc_channel1.sv: register-level tests of the channel 1 timer
// assumes: design, far side model and checker compiled before this file
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin miscompares++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end

module tb_tcc_channel1;
  logic clk = 1'b0, sys_rst = 1'b1, wr_en = 1'b0, rd_en = 1'b0, ext_a = 1'b0, ext_b = 1'b0;
  logic tick_up = 1'b0, tick_down = 1'b0, ch0_a_event = 1'b0, ch0_b_event = 1'b0;
  logic sync_clear = 1'b0, e;
  logic [15:0] addr = 16'h0000, wr_data = 16'h0000, rd_data;
  logic pin_a_in, pin_a_out, pin_a_oe_n, pin_b_in, pin_b_out, pin_b_oe_n, adc_start, irq;
  logic [3:0] c;
  logic [3:0] cap_code [5] = '{4'h8, 4'h9, 4'h9, 4'ha, 4'ha};
  logic cap_lvl [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
  logic [15:0] cap_exp [5] = '{16'h1111, 16'h2222, 16'h2222, 16'h4444, 16'h5555};
  int miscompares = 0, checks_done = 0, cycles = 0, exp_adc = 0, adc_count;

  tcc_channel1 i_tcc_channel1 (.clk(clk), .sys_rst(sys_rst), .addr(addr), .wr_data(wr_data),
    .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .tick_up(tick_up), .tick_down(tick_down),
    .ch0_a_event(ch0_a_event), .ch0_b_event(ch0_b_event), .sync_clear(sync_clear),
    .pin_a_in(pin_a_in), .pin_a_out(pin_a_out), .pin_a_oe_n(pin_a_oe_n), .pin_b_in(pin_b_in),
    .pin_b_out(pin_b_out), .pin_b_oe_n(pin_b_oe_n), .adc_start(adc_start), .irq(irq));
  tcc_far_side i_tcc_far_side (.clk(clk), .sys_rst(sys_rst), .pin_a_out(pin_a_out),
    .pin_a_oe_n(pin_a_oe_n), .pin_b_out(pin_b_out), .pin_b_oe_n(pin_b_oe_n), .ext_a(ext_a),
    .ext_b(ext_b), .adc_start(adc_start), .pin_a_in(pin_a_in), .pin_b_in(pin_b_in),
    .adc_count(adc_count));

  ////////////////////////////////////////////////////////////////////////////////
  // bus cycles, event pulses and waits
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [15:0] x, input string nm);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    `CHK(nm, x, rd_data)
  endtask
  // one-cycle pulse on {down, up, sync clear, channel 0 b, channel 0 a}
  task automatic ev(input logic [4:0] m);
    @(posedge clk);
    {tick_down, tick_up, sync_clear, ch0_b_event, ch0_a_event} <= m;
    @(posedge clk);
    {tick_down, tick_up, sync_clear, ch0_b_event, ch0_a_event} <= 5'h00;
  endtask
  task automatic pause();
    repeat (5) @(posedge clk);
    #1;
  endtask
  task automatic complete_run();
    if (miscompares == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // clock and hang guard
  initial begin
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      miscompares++;
      complete_run();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    rd(16'hffe6, 16'h0000, "cnt_reset");
    rd(16'hffe8, 16'hffff, "gen_a_reset");
    rd(16'hffea, 16'hffff, "gen_b_reset");
    rd(16'hffe3, 16'h0000, "unmapped");
    // down pulses are ignored in plain mode and count in phase counting mode
    wr(16'hffe6, 16'h0010);
    ev(5'h10);
    rd(16'hffe6, 16'h0010, "up_only");
    wr(16'hffe1, 16'h0004);
    ev(5'h10);
    rd(16'hffe6, 16'h000f, "phase_down");
    wr(16'hffe1, 16'h0000);
    // every compare code on both pins, conversion start enabled for odd codes
    wr(16'hffe8, 16'h0013);
    wr(16'hffea, 16'h0013);
    for (int i = 0; i < 8; i++) begin
      c = 4'(i);
      wr(16'hffe4, {8'h00, c[0], 7'h00});
      wr(16'hffe2, {8'h00, c, c});
      wr(16'hffe6, 16'h0012);
      pause();
      `CHK("oe_a", c[1:0] == 2'h0, pin_a_oe_n)
      `CHK("oe_b", c[1:0] == 2'h0, pin_b_oe_n)
      if (c[1:0] != 2'h0) `CHK("start_a", c[2], pin_a_out)
      if (c[1:0] != 2'h0) `CHK("start_b", c[2], pin_b_out)
      ev(5'h08);
      pause();
      e = c[1:0] == 2'h1 ? 1'b0 : (c[1:0] == 2'h2 ? 1'b1 : ~c[2]);
      if (c[1:0] != 2'h0) `CHK("match_a", e, pin_a_out)
      if (c[1:0] != 2'h0) `CHK("match_b", e, pin_b_out)
      exp_adc += int'(c[0]);
      `CHK("adc_count", exp_adc, adc_count)
    end
    // flags clear by a written zero, a written one leaves them
    wr(16'hffe4, 16'h0003);
    rd(16'hffe5, 16'h0003, "flags");
    `CHK("irq_on", 1'b1, irq)
    wr(16'hffe5, 16'h00ff);
    rd(16'hffe5, 16'h0003, "flags_ones");
    wr(16'hffe5, 16'h0001);
    rd(16'hffe5, 16'h0001, "flags_b_clr");
    wr(16'hffe5, 16'h0000);
    rd(16'hffe5, 16'h0000, "flags_clr");
    `CHK("irq_off", 1'b0, irq)
    // pin edges: rise, fall, ignored rise, both edges twice
    for (int i = 0; i < 5; i++) begin
      wr(16'hffe2, {8'h00, cap_code[i], cap_code[i]});
      wr(16'hffe6, 16'(16'h1111 * (i + 1)));
      pause();
      @(posedge clk);
      ext_a <= cap_lvl[i];
      ext_b <= cap_lvl[i];
      pause();
      rd(16'hffe8, cap_exp[i], "cap_a");
      rd(16'hffea, cap_exp[i], "cap_b");
    end
    // channel 0 events capture, then clearing by sync and by register a
    wr(16'hffe2, 16'h00cc);
    wr(16'hffe6, 16'h6666);
    ev(5'h01);
    rd(16'hffe8, 16'h6666, "ch0_a");
    rd(16'hffea, 16'h5555, "ch0_a_not_b");
    ev(5'h02);
    rd(16'hffea, 16'h6666, "ch0_b");
    wr(16'hffe0, 16'h0060);
    ev(5'h04);
    rd(16'hffe6, 16'h0000, "sync_clr");
    wr(16'hffe0, 16'h0020);
    wr(16'hffe6, 16'h0100);
    ev(5'h01);
    rd(16'hffe8, 16'h0100, "cap_clr_a");
    rd(16'hffe6, 16'h0000, "clr_on_a");
    // cascade source counts down through zero and back up, flags masked, then clear on b
    wr(16'hffe5, 16'h0000);
    wr(16'hffe0, 16'h0047);
    wr(16'hffe6, 16'h0000);
    ev(5'h10);
    rd(16'hffe6, 16'hffff, "cascade_down");
    ev(5'h08);
    rd(16'hffe5, 16'h0030, "wrap_flags");
    `CHK("irq_masked", 1'b0, irq)
    wr(16'hffe6, 16'h0200);
    ev(5'h02);
    rd(16'hffea, 16'h0200, "cap_clr_b");
    rd(16'hffe6, 16'h0000, "clr_on_b");
    complete_run();
  end
endmodule // tb_tcc_channel1

bind tcc_channel1 tcc_channel1_checker i_tcc_channel1_checker (.clk(clk), .sys_rst(sys_rst),
  .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
  .tick_up(tick_up), .tick_down(tick_down), .ch0_a_event(ch0_a_event),
  .ch0_b_event(ch0_b_event), .sync_clear(sync_clear), .pin_a_in(pin_a_in),
  .pin_a_out(pin_a_out), .pin_a_oe_n(pin_a_oe_n), .pin_b_in(pin_b_in), .pin_b_out(pin_b_out),
  .pin_b_oe_n(pin_b_oe_n), .adc_start(adc_start), .irq(irq));

`default_nettype wire
